//--- design/cmpc_top.sv
// chirp modem frame kind and modulation settings, axi4-lite slave
`default_nettype none
// Contract
// - frame kind selection picks the frame format and the active modem.
// - frame kind query returns the currently selected kind.
// - hopping kind enables modulator and hopping; host builds frames and hops (code raises hop_en only, no modem enable).
// - spread order 5 to 12 accepted; symbol holds 2^order chips.
// - orders 5 and 6 work with implicit and explicit headers.
// - symbol rate equals bandwidth divided by 2^order.
// - bandwidth codes 0 to 9 decode to 7.81 through 500 kHz.
// - up to 250 kHz use low-IF double conversion; 500 kHz zero-IF.
// - coding rate codes 1 to 4 mean 4/5 to 4/8.
// - coding rate travels in the header when one is present.
// - low rate option gives order minus two bits per symbol.
module cmpc_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [1:0] frame_kind,
  output logic chirp_modem_en,
  output logic fsk_modem_en,
  output logic hop_en,
  output logic [3:0] spread_order,
  output logic [3:0] chirp_bandwidth_code,
  output logic [2:0] coding_rate_code,
  output logic low_rate_option,
  output logic zero_if_path,
  output logic [3:0] bits_per_symbol,
  output logic [12:0] chips_per_symbol
);
  // bandwidth in hz for codes 0..9 (fractional hz dropped)
  function automatic logic [19:0] bw_hz(input logic [3:0] code);
    case (code)
      4'h0: bw_hz = 20'd7812;
      4'h1: bw_hz = 20'd10416;
      4'h2: bw_hz = 20'd15625;
      4'h3: bw_hz = 20'd20833;
      4'h4: bw_hz = 20'd31250;
      4'h5: bw_hz = 20'd41666;
      4'h6: bw_hz = 20'd62500;
      4'h7: bw_hz = 20'd125000;
      4'h8: bw_hz = 20'd250000;
      4'h9: bw_hz = 20'd500000;
      default: bw_hz = 20'd0;
    endcase
  endfunction

  function automatic logic kind_ok(input logic [1:0] k);
    kind_ok = (k == cmpc_pkg::CMPC_KIND_FSK) ||
      (k == cmpc_pkg::CMPC_KIND_CHIRP) || (k == cmpc_pkg::CMPC_KIND_HOP);
  endfunction

  function automatic logic mod_ok(input cmpc_pkg::cmpc_mod_t m);
    // orders 5 and 6 pass the same way whatever header mode follows
    mod_ok = (m.spread_order >= cmpc_pkg::SF_MIN) &&
      (m.spread_order <= cmpc_pkg::SF_MAX) &&
      (m.chirp_bandwidth_code <= cmpc_pkg::BW_MAX) &&
      (m.coding_rate_code >= cmpc_pkg::CR_MIN) &&
      (m.coding_rate_code <= cmpc_pkg::CR_MAX);
  endfunction

  // write channel state
  logic aw_ff, nxt_aw;
  logic w_ff, nxt_w;
  logic [7:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  // read channel state
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  // configuration state
  logic [1:0] kind_ff, nxt_kind;
  cmpc_pkg::cmpc_mod_t mod_ff, nxt_mod;
  logic rej_kind_ff, nxt_rej_kind;
  logic rej_mod_ff, nxt_rej_mod;
  logic zero_if_ff, nxt_zero_if;
  logic [3:0] bps_ff, nxt_bps;
  logic [12:0] chips_ff, nxt_chips;

  cmpc_pkg::cmpc_mod_t wmod;
  logic do_write;
  logic [31:0] status_word;

  always_comb begin
    wmod.spread_order = wdata_ff[cmpc_pkg::SF_LSB +: 4];
    wmod.chirp_bandwidth_code = wdata_ff[cmpc_pkg::BW_LSB +: 4];
    wmod.coding_rate_code = wdata_ff[cmpc_pkg::CR_LSB +: 3];
    wmod.low_rate_option = wdata_ff[cmpc_pkg::LDR_BIT];
  end

  assign do_write = aw_ff && w_ff && !bvalid_ff;

  // axi write path: address and data taken in either order
  always_comb begin
    nxt_aw = aw_ff;
    nxt_w = w_ff;
    nxt_awaddr = awaddr_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_kind = kind_ff;
    nxt_mod = mod_ff;
    nxt_rej_kind = rej_kind_ff;
    nxt_rej_mod = rej_mod_ff;
    if (s_axi_awvalid && !aw_ff) begin
      nxt_aw = 1'b1;
      nxt_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_ff) begin
      nxt_w = 1'b1;
      nxt_wdata = s_axi_wdata;
      nxt_wstrb = s_axi_wstrb;
    end
    if (do_write) begin
      nxt_aw = 1'b0;
      nxt_w = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = cmpc_pkg::RESP_OKAY;
      case (awaddr_ff)
        cmpc_pkg::OFS_FRAME_KIND: begin
          // bad code is refused; previous kind stays
          if (kind_ok(wdata_ff[1:0])) begin
            nxt_kind = wdata_ff[1:0];
            nxt_rej_kind = 1'b0;
          end else begin
            nxt_rej_kind = 1'b1;
          end
        end
        cmpc_pkg::OFS_MOD_SET: begin
          // whole set taken or none, so a partial word never applies
          if (mod_ok(wmod) && wstrb_ff[3:0] == 4'hF) begin
            nxt_mod = wmod;
            nxt_rej_mod = 1'b0;
          end else begin
            nxt_rej_mod = 1'b1;
          end
        end
        cmpc_pkg::OFS_STATUS, cmpc_pkg::OFS_SYM_DIV,
        cmpc_pkg::OFS_BW_HZ, cmpc_pkg::OFS_BITS_SYM: begin
          nxt_bresp = cmpc_pkg::RESP_OKAY;
        end
        default: nxt_bresp = cmpc_pkg::RESP_SLVERR;
      endcase
    end
    if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  // derived modem controls follow the stored settings
  always_comb begin
    nxt_zero_if = (mod_ff.chirp_bandwidth_code == cmpc_pkg::BW_ZERO_IF);
    nxt_chips = 13'h0001 << mod_ff.spread_order;
    if (mod_ff.low_rate_option) begin
      nxt_bps = mod_ff.spread_order - cmpc_pkg::LDR_BITS_LESS;
    end else begin
      nxt_bps = mod_ff.spread_order;
    end
  end

  assign status_word = {26'h000_0000, rej_mod_ff, rej_kind_ff,
    zero_if_ff, 1'b0, kind_ff};

  // axi read path
  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (s_axi_arvalid && !rvalid_ff) begin
      nxt_rvalid = 1'b1;
      nxt_rresp = cmpc_pkg::RESP_OKAY;
      case (s_axi_araddr)
        cmpc_pkg::OFS_FRAME_KIND: nxt_rdata = {30'h0000_0000, kind_ff};
        cmpc_pkg::OFS_MOD_SET: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rdata[cmpc_pkg::SF_LSB +: 4] = mod_ff.spread_order;
          nxt_rdata[cmpc_pkg::BW_LSB +: 4] = mod_ff.chirp_bandwidth_code;
          nxt_rdata[cmpc_pkg::CR_LSB +: 3] = mod_ff.coding_rate_code;
          nxt_rdata[cmpc_pkg::LDR_BIT] = mod_ff.low_rate_option;
        end
        cmpc_pkg::OFS_STATUS: nxt_rdata = status_word;
        // symbol rate is bandwidth over this divisor
        cmpc_pkg::OFS_SYM_DIV: nxt_rdata = {19'h0_0000, chips_ff};
        cmpc_pkg::OFS_BW_HZ:
          nxt_rdata = {12'h000, bw_hz(mod_ff.chirp_bandwidth_code)};
        cmpc_pkg::OFS_BITS_SYM: nxt_rdata = {28'h000_0000, bps_ff};
        default: begin
          nxt_rdata = 32'h0000_0000;
          nxt_rresp = cmpc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff <= 1'b0;
      w_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= cmpc_pkg::RESP_OKAY;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= cmpc_pkg::RESP_OKAY;
      kind_ff <= cmpc_pkg::KIND_RESET;
      mod_ff.spread_order <= cmpc_pkg::SF_RESET;
      mod_ff.chirp_bandwidth_code <= cmpc_pkg::BW_RESET;
      mod_ff.coding_rate_code <= cmpc_pkg::CR_RESET;
      mod_ff.low_rate_option <= 1'b0;
      rej_kind_ff <= 1'b0;
      rej_mod_ff <= 1'b0;
      zero_if_ff <= 1'b0;
      bps_ff <= cmpc_pkg::SF_RESET;
      chips_ff <= 13'h0001 << cmpc_pkg::SF_RESET;
    end else begin
      aw_ff <= nxt_aw;
      w_ff <= nxt_w;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      kind_ff <= nxt_kind;
      mod_ff <= nxt_mod;
      rej_kind_ff <= nxt_rej_kind;
      rej_mod_ff <= nxt_rej_mod;
      zero_if_ff <= nxt_zero_if;
      bps_ff <= nxt_bps;
      chips_ff <= nxt_chips;
    end
  end

  // modem enables and outputs, each from a flip-flop; the three readies through an inverter
  logic chirp_en_ff, fsk_en_ff, hop_en_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chirp_en_ff <= 1'b0;
      fsk_en_ff <= 1'b0;
      hop_en_ff <= 1'b0;
    end else begin
      // hopping raises hop_en only, with no modulator enable; framing is host's
      chirp_en_ff <= (kind_ff == cmpc_pkg::CMPC_KIND_CHIRP);
      fsk_en_ff <= (kind_ff == cmpc_pkg::CMPC_KIND_FSK);
      hop_en_ff <= (kind_ff == cmpc_pkg::CMPC_KIND_HOP);
    end
  end

  assign s_axi_awready = !aw_ff;
  assign s_axi_wready = !w_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign frame_kind = kind_ff;
  assign chirp_modem_en = chirp_en_ff;
  assign fsk_modem_en = fsk_en_ff;
  assign hop_en = hop_en_ff;
  assign spread_order = mod_ff.spread_order;
  assign chirp_bandwidth_code = mod_ff.chirp_bandwidth_code;
  assign coding_rate_code = mod_ff.coding_rate_code;
  assign low_rate_option = mod_ff.low_rate_option;
  assign zero_if_path = zero_if_ff;
  assign bits_per_symbol = bps_ff;
  assign chips_per_symbol = chips_ff;
endmodule
`default_nettype wire

//--- include/cmpc_pkg.sv
// package for the chirp modem parameter configuration block
`default_nettype none
package cmpc_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_FRAME_KIND = 8'h00;
  localparam logic [7:0] OFS_MOD_SET = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_SYM_DIV = 8'h0C;
  localparam logic [7:0] OFS_BW_HZ = 8'h10;
  localparam logic [7:0] OFS_BITS_SYM = 8'h14;
  // frame kind codes
  typedef enum logic [1:0] {
    CMPC_KIND_FSK = 2'b00,
    CMPC_KIND_CHIRP = 2'b01,
    CMPC_KIND_HOP = 2'b11
  } cmpc_kind_t;
  localparam logic [1:0] KIND_RESET = 2'h0;
  // field positions within the modulation word
  localparam int SF_LSB = 0;
  localparam int BW_LSB = 8;
  localparam int CR_LSB = 16;
  localparam int LDR_BIT = 24;
  // legal ranges
  localparam logic [3:0] SF_MIN = 4'h5;
  localparam logic [3:0] SF_MAX = 4'hC;
  localparam logic [3:0] BW_MAX = 4'h9;
  localparam logic [3:0] BW_ZERO_IF = 4'h9;
  localparam logic [2:0] CR_MIN = 3'h1;
  localparam logic [2:0] CR_MAX = 3'h4;
  localparam logic [3:0] LDR_BITS_LESS = 4'h2;
  // reset settings: order 7, 125 kHz, rate 4/5, option off
  localparam logic [3:0] SF_RESET = 4'h7;
  localparam logic [3:0] BW_RESET = 4'h7;
  localparam logic [2:0] CR_RESET = 3'h1;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef struct packed {
    logic [3:0] spread_order;
    logic [3:0] chirp_bandwidth_code;
    logic [2:0] coding_rate_code;
    logic low_rate_option;
  } cmpc_mod_t;
endpackage
`default_nettype wire

//--- verification/cmpc_properties.sv
// port-level assertions for the chirp modem parameter block
`default_nettype none
module cmpc_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] frame_kind,
  input wire logic chirp_modem_en,
  input wire logic fsk_modem_en,
  input wire logic hop_en,
  input wire logic [3:0] spread_order,
  input wire logic [3:0] chirp_bandwidth_code,
  input wire logic [2:0] coding_rate_code,
  input wire logic low_rate_option,
  input wire logic zero_if_path,
  input wire logic [3:0] bits_per_symbol,
  input wire logic [12:0] chips_per_symbol
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_kind_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == cmpc_pkg::OFS_FRAME_KIND;
  endsequence
  sequence s_change;
    {frame_kind, spread_order, chirp_bandwidth_code, coding_rate_code,
     low_rate_option} != $past({frame_kind, spread_order,
     chirp_bandwidth_code, coding_rate_code, low_rate_option});
  endsequence
  property p_query;
    s_kind_read |=> s_axi_rvalid && s_axi_rdata[1:0] == $past(frame_kind);
  endproperty
  // enables lag the kind by one cycle, so skip the edge right after reset
  property p_modem_sel;
    $past(aresetn) |-> chirp_modem_en == ($past(frame_kind) == 2'h1) &&
      fsk_modem_en == ($past(frame_kind) == 2'h0);
  endproperty
  property p_hop;
    $past(aresetn) |-> hop_en == ($past(frame_kind) == 2'h3);
  endproperty
  property p_chips;
    chips_per_symbol == (13'h1 << $past(spread_order));
  endproperty
  property p_bits;
    bits_per_symbol == ($past(low_rate_option) ? $past(spread_order) - 4'h2
      : $past(spread_order));
  endproperty
  property p_zif;
    zero_if_path == ($past(chirp_bandwidth_code) == 4'h9);
  endproperty
  property p_range;
    spread_order >= 4'h5 && spread_order <= 4'hc &&
      chirp_bandwidth_code <= 4'h9 &&
      coding_rate_code >= 3'h1 && coding_rate_code <= 3'h4;
  endproperty
  property p_hold;
    $past(aresetn) ##0 s_change |-> $rose(s_axi_bvalid);
  endproperty
  a_query: assert property (p_query) else $error("kind read wrong");
  a_modem_sel: assert property (p_modem_sel) else $error("modem en");
  a_hop: assert property (p_hop) else $error("hop enable wrong");
  a_chips: assert property (p_chips) else $error("chips wrong");
  a_bits: assert property (p_bits) else $error("bits wrong");
  a_zif: assert property (p_zif) else $error("zero-if path wrong");
  a_range: assert property (p_range) else $error("bad setting");
  a_hold: assert property (p_hold) else $error("setting drift");
endmodule
bind cmpc_top cmpc_properties cmpc_properties_i (.*);
`default_nettype wire

//--- verification/cmpc_host.sv
// host model: axi4-lite master issuing configuration commands
`default_nettype none
module cmpc_host (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_rready = 1'b0;
  end
  // lag delays the response ready, so slow hosts are exercised too
  // handshakes are judged at the falling edge, where the slave's registered
  // outputs have settled, so the rising edge never races the design
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input int lag, output logic [1:0] resp);
    int n;
    logic aw_hs, w_hs, b_hs;
    n = 0;
    b_hs = 1'b0;
    resp = 2'b00;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      aw_hs = s_axi_awvalid && s_axi_awready;
      w_hs = s_axi_wvalid && s_axi_wready;
      b_hs = s_axi_bvalid && s_axi_bready;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw_hs) s_axi_awvalid <= 1'b0;
      if (w_hs) s_axi_wvalid <= 1'b0;
      n++;
      if (n >= lag && !b_hs) s_axi_bready <= 1'b1;
    end while (!b_hs);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] resp);
    logic ar_hs, r_hs;
    r_hs = 1'b0;
    v = 32'h0000_0000;
    resp = 2'b00;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      ar_hs = s_axi_arvalid && s_axi_arready;
      r_hs = s_axi_rvalid && s_axi_rready;
      v = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar_hs) s_axi_arvalid <= 1'b0;
    end while (!r_hs);
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verification/chirp_modem_param_config_test.sv
// self-checking bench for the chirp modem parameter block
`default_nettype none
module chirp_modem_param_config_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, lf, w, m, d;
  logic [3:0] s_axi_wstrb, spread_order, chirp_bandwidth_code, bits_per_symbol;
  logic [1:0] s_axi_bresp, s_axi_rresp, frame_kind, r, exp_k;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic chirp_modem_en, fsk_modem_en, hop_en, low_rate_option, zero_if_path, ok;
  logic [2:0] coding_rate_code;
  logic [12:0] chips_per_symbol;
  logic [1:0] kinds [5] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h1};
  logic [31:0] corner [8] = '{32'h0101_0905, 32'h0004_080c, 32'h0001_0004,
    32'h0001_000d, 32'h0001_0a07, 32'h0005_0007, 32'h0000_0007, 32'h0103_0006};
  int bad_count = 0;
  int n_tests = 0;
  cmpc_top cmpc_top_i (.*);
  cmpc_host cmpc_host_i (.*);
  always #10 aclk = ~aclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // only bandwidths whose hertz value is exact are compared
  function automatic logic [31:0] bw_hz(input logic [3:0] c);
    case (c)
      4'h4: return 32'h0000_7a12;
      4'h6: return 32'h0000_f424;
      4'h7: return 32'h0001_e848;
      4'h8: return 32'h0003_d090;
      4'h9: return 32'h0007_a120;
      default: return 32'h0000_0000;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    bad_count++;
    conclude();
  end
  initial begin
    lf = 32'h75f4_c22c;
    m = 32'h0001_0707;
    exp_k = 2'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("reset chips", {19'h0, chips_per_symbol}, 32'h0000_0080);
    // kind first, modulation after it
    foreach (kinds[i]) begin
      cmpc_host_i.wr(cmpc_pkg::OFS_FRAME_KIND, {30'h0, kinds[i]}, i, r);
      if (kinds[i] != 2'h2) exp_k = kinds[i];
      cmpc_host_i.rd(cmpc_pkg::OFS_FRAME_KIND, d, r);
      chk("kind", {30'h0, d[1:0]}, {30'h0, exp_k});
      chk("enables", {29'h0, chirp_modem_en, fsk_modem_en, hop_en},
          {29'h0, exp_k == 2'h1, exp_k == 2'h0, exp_k == 2'h3});
    end
    // preamble, carrier band, rate policy, ldr choice and matching order at
    // the far end stay with the host; the block never sees them
    for (int i = 0; i < 48; i++) begin
      lf = lfsr(lf);
      w = (i < 8) ? corner[i] : (lf & 32'h0107_0f0f);
      cmpc_host_i.wr(cmpc_pkg::OFS_MOD_SET, w, int'(lf[9:8]), r);
      ok = w[3:0] >= 4'h5 && w[3:0] <= 4'hc && w[11:8] <= 4'h9 &&
           w[18:16] >= 3'h1 && w[18:16] <= 3'h4;
      if (ok) m = w;
      cmpc_host_i.rd(cmpc_pkg::OFS_SYM_DIV, d, r);
      chk("chips", d, 32'h1 << m[3:0]);
      cmpc_host_i.rd(cmpc_pkg::OFS_BITS_SYM, d, r);
      chk("bits", d, m[24] ? {28'h0, m[3:0] - 4'h2} : {28'h0, m[3:0]});
      cmpc_host_i.rd(cmpc_pkg::OFS_STATUS, d, r);
      chk("status", {30'h0, d[5], d[3]}, {30'h0, !ok, m[11:8] == 4'h9});
      cmpc_host_i.rd(cmpc_pkg::OFS_BW_HZ, d, r);
      if (bw_hz(m[11:8]) != 0) chk("bw", d, bw_hz(m[11:8]));
      chk("settings", {20'h0, spread_order, chirp_bandwidth_code,
          low_rate_option, coding_rate_code},
          {20'h0, m[3:0], m[11:8], m[24], m[18:16]});
    end
    cmpc_host_i.wr(8'h40, 32'h0001_0005, 0, r);
    chk("unmapped wr", {30'h0, r}, 32'h0000_0002);
    cmpc_host_i.rd(8'h40, d, r);
    chk("unmapped rd", d ^ {30'h0, r}, 32'h0000_0002);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk("rst kind", {26'h0, frame_kind, spread_order}, 32'h0000_0007);
    conclude();
  end
endmodule
`default_nettype wire
